// ### hdl/gdbt_pkg.sv
// Register map, field layout and reset values of the blanking and turn-off delay bank.
// Assumes a register-access front end that hands over decoded 16-bit words.
package gdbt_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] GDBT_DESATURATION_SUPERVISION_OFS = 8'h18;
    localparam logic [7:0] GDBT_OCP_OFS = 8'h19;
    localparam logic [7:0] GDBT_RTOFF_OFS = 8'h1a;
    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int GDBT_CNT_HI = 15;
    localparam int GDBT_CNT_LO = 8;
    localparam int GDBT_LFR_BIT = 1;
    localparam int GDBT_PAR_BIT = 0;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] GDBT_DESATURATION_SUPERVISION_RST = 16'h2000;
    localparam logic [15:0] GDBT_OCP_RST = 16'h0001;
    localparam logic [15:0] GDBT_RTOFF_RST = 16'h0001;
    // ----------------------------------------
    // Field value limits
    // ----------------------------------------
    localparam logic [7:0] GDBT_ZERO8 = 8'h00;
    localparam logic [7:0] GDBT_ONE8 = 8'h01;
    localparam logic [7:0] GDBT_DESATURATION_SUPERVISION_MIN = 8'h0a;
    localparam logic [7:0] GDBT_OCP_MAX = 8'h2f;
    localparam logic [7:0] GDBT_RTOFF_MIN = 8'h02;
endpackage : gdbt_pkg

// ### hdl/gdbt_timer.sv
// One blanking or delay timer counting on a secondary oscillator enable.
// Assumes start is a one-cycle pulse from the switching event detector.
`timescale 1ns/10ps
module gdbt_timer
    import gdbt_pkg::*;
#(
    parameter int W = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic [W-1:0] count,
    output logic active
);
    typedef struct packed
    {
        logic [W-1:0] cnt;
        logic act;
    } gdbt_tmr_s;

    gdbt_tmr_s st_reg;
    gdbt_tmr_s st_next;

    initial
    begin
        if (W < 1)
        begin
            $error("gdbt_timer width too small");
        end
    end

    always_comb
    begin
        st_next = st_reg;
        if (start)
        begin
            st_next.cnt = count;
            st_next.act = (count != '0);
        end
        else if (st_reg.act && tick)
        begin
            st_next.cnt = st_reg.cnt - W'(1);
            if (st_reg.cnt == W'(1))
            begin
                st_next.act = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign active = st_reg.act;
endmodule : gdbt_timer

// ### hdl/gdbt_bank.sv
// Desaturation and overcurrent blanking and regular turn-off delay registers and timers.
// Assumes the SPI front end on SYS_CLK delivers a decoded word access and frame verdict.
//
// Functional notes
// - Desaturation_supervision blanking length from bits 15:8
// - Overcurrent blanking length from bits 15:8
// - Zero overcurrent field disables blanking generation
// - Turn-off delay from bits 15:8
// - Zero delay field disables two-level turn-off
// - Bit 1 flags last frame rejected
// - Bit 0 is odd parity of word
`timescale 1ns/10ps
module gdbt_bank
    import gdbt_pkg::*;
#(
    parameter int OSC_DIV = 2,
    parameter int SYNC_DIV = 2
)
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Register access from frame decoder
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic FRAME_DONE,
    input wire logic FRAME_BAD,
    output logic [15:0] REG_RDATA,
    output logic REG_RVALID,
    // Switching events and comparator pins
    input wire logic SWITCH_EVT,
    input wire logic OFF_EVT,
    input wire logic DESATURATION_SUPERVISION_CMP,
    input wire logic OCP_CMP,
    // Qualified outputs
    output logic DESATURATION_SUPERVISION_FAULT,
    output logic OCP_FAULT,
    output logic OCP_BLANK_ON,
    output logic TWO_LEVEL_TURN_OFF_ON,
    output logic TWO_LEVEL_TURN_OFF_ACTIVE
);
    typedef struct packed
    {
        logic [7:0] desaturation_supervision_blank_count;
        logic [7:0] overcurrent_blank_count;
        logic [7:0] regular_off_delay_count;
        logic last_frame_rejected;
        logic [15:0] rdata;
        logic rvalid;
        logic [7:0] osc_div;
        logic [7:0] sync_div;
        logic [1:0] desaturation_supervision_sync;
        logic [1:0] ocp_sync;
        logic desaturation_supervision_fault;
        logic ocp_fault;
        logic ocp_on;
        logic two_level_turn_off_on;
        logic two_level_turn_off_out;
    } gdbt_bank_s;

    gdbt_bank_s st_reg;
    gdbt_bank_s st_next;
    logic osc_tick;
    logic sync_tick;
    logic desaturation_supervision_blank;
    logic ocp_blank;
    logic two_level_turn_off_act;

    initial
    begin
        if (OSC_DIV < 1 || OSC_DIV > 256 || SYNC_DIV < 1 || SYNC_DIV > 256)
        begin
            $error("gdbt_bank divider out of range");
        end
    end

    // ----------------------------------------
    // Read word assembly
    // ----------------------------------------
    function automatic logic [15:0] gdbt_word(input logic [7:0] cnt, input logic lfr);
        logic [15:0] w;
        w = '0;
        w[GDBT_CNT_HI:GDBT_CNT_LO] = cnt;
        w[GDBT_LFR_BIT] = lfr;
        w[GDBT_PAR_BIT] = ~(^w[GDBT_CNT_HI:GDBT_LFR_BIT]);
        return w;
    endfunction : gdbt_word

    assign osc_tick = (st_reg.osc_div == 8'(OSC_DIV - 1));
    assign sync_tick = (st_reg.sync_div == 8'(SYNC_DIV - 1));

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        st_next.osc_div = osc_tick ? 8'h00 : st_reg.osc_div + 8'h01;
        st_next.sync_div = sync_tick ? 8'h00 : st_reg.sync_div + 8'h01;
        st_next.desaturation_supervision_sync = {st_reg.desaturation_supervision_sync[0], DESATURATION_SUPERVISION_CMP};
        st_next.ocp_sync = {st_reg.ocp_sync[0], OCP_CMP};
        if (REG_WR && !FRAME_BAD)
        begin
            case (REG_ADDR)
                GDBT_DESATURATION_SUPERVISION_OFS:
                begin
                    st_next.desaturation_supervision_blank_count = REG_WDATA[GDBT_CNT_HI:GDBT_CNT_LO];
                end
                GDBT_OCP_OFS:
                begin
                    st_next.overcurrent_blank_count = REG_WDATA[GDBT_CNT_HI:GDBT_CNT_LO];
                end
                GDBT_RTOFF_OFS:
                begin
                    st_next.regular_off_delay_count = REG_WDATA[GDBT_CNT_HI:GDBT_CNT_LO];
                end
                default:
                begin
                end
            endcase
        end
        if (FRAME_DONE)
        begin
            st_next.last_frame_rejected = FRAME_BAD;
        end
        if (REG_RD)
        begin
            st_next.rvalid = 1'b1;
            case (REG_ADDR)
                GDBT_DESATURATION_SUPERVISION_OFS:
                    st_next.rdata = gdbt_word(st_reg.desaturation_supervision_blank_count, st_reg.last_frame_rejected);
                GDBT_OCP_OFS:
                    st_next.rdata = gdbt_word(st_reg.overcurrent_blank_count,
                        st_reg.last_frame_rejected);
                GDBT_RTOFF_OFS:
                    st_next.rdata = gdbt_word(st_reg.regular_off_delay_count,
                        st_reg.last_frame_rejected);
                default:
                    st_next.rdata = gdbt_word(GDBT_ZERO8, st_reg.last_frame_rejected);
            endcase
        end
        st_next.desaturation_supervision_fault = st_reg.desaturation_supervision_sync[1] && !desaturation_supervision_blank;
        st_next.ocp_fault = st_reg.ocp_sync[1] && !ocp_blank;
        st_next.ocp_on = (st_reg.overcurrent_blank_count != GDBT_ZERO8);
        st_next.two_level_turn_off_on = (st_reg.regular_off_delay_count != GDBT_ZERO8);
        st_next.two_level_turn_off_out = two_level_turn_off_act;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            st_reg <= '0;
            st_reg.desaturation_supervision_blank_count <= GDBT_DESATURATION_SUPERVISION_RST[GDBT_CNT_HI:GDBT_CNT_LO];
            st_reg.overcurrent_blank_count <= GDBT_OCP_RST[GDBT_CNT_HI:GDBT_CNT_LO];
            st_reg.regular_off_delay_count <= GDBT_RTOFF_RST[GDBT_CNT_HI:GDBT_CNT_LO];
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Timers
    // ----------------------------------------
    gdbt_timer #(.W(8)) u_desaturation_supervision
    (
        .clk(SYS_CLK),
        .rst(RST),
        .tick(osc_tick),
        .start(SWITCH_EVT),
        .count(st_reg.desaturation_supervision_blank_count),
        .active(desaturation_supervision_blank)
    );

    gdbt_timer #(.W(8)) u_ocp
    (
        .clk(SYS_CLK),
        .rst(RST),
        .tick(osc_tick),
        .start(SWITCH_EVT),
        .count(st_reg.overcurrent_blank_count),
        .active(ocp_blank)
    );

    gdbt_timer #(.W(8)) u_two_level_turn_off
    (
        .clk(SYS_CLK),
        .rst(RST),
        .tick(sync_tick),
        .start(OFF_EVT),
        .count(st_reg.regular_off_delay_count),
        .active(two_level_turn_off_act)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign REG_RDATA = st_reg.rdata;
    assign REG_RVALID = st_reg.rvalid;
    assign DESATURATION_SUPERVISION_FAULT = st_reg.desaturation_supervision_fault;
    assign OCP_FAULT = st_reg.ocp_fault;
    assign OCP_BLANK_ON = st_reg.ocp_on;
    assign TWO_LEVEL_TURN_OFF_ON = st_reg.two_level_turn_off_on;
    assign TWO_LEVEL_TURN_OFF_ACTIVE = st_reg.two_level_turn_off_out;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_parity;
        @(posedge SYS_CLK) disable iff (RST) REG_RVALID |-> (^REG_RDATA == 1'b1);
    endproperty
    a_parity: assert property (p_parity) else $error("even parity on read word");

    property p_reserved;
        @(posedge SYS_CLK) disable iff (RST)
            REG_RVALID |-> (REG_RDATA[GDBT_CNT_LO-1:GDBT_LFR_BIT+1] == '0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_lfr;
        @(posedge SYS_CLK) disable iff (RST)
            (FRAME_DONE && FRAME_BAD) ##1 !FRAME_DONE ##1 REG_RD |=> REG_RDATA[GDBT_LFR_BIT];
    endproperty
    a_lfr: assert property (p_lfr) else $error("rejected frame not flagged");

    property p_desaturation_supervision_wr;
        @(posedge SYS_CLK) disable iff (RST)
            (REG_WR && !FRAME_BAD && REG_ADDR == GDBT_DESATURATION_SUPERVISION_OFS)
            |=> (st_reg.desaturation_supervision_blank_count == $past(REG_WDATA[GDBT_CNT_HI:GDBT_CNT_LO]));
    endproperty
    a_desaturation_supervision_wr: assert property (p_desaturation_supervision_wr) else $error("desaturation_supervision count not stored");

    property p_ocp_wr;
        @(posedge SYS_CLK) disable iff (RST)
            (REG_WR && !FRAME_BAD && REG_ADDR == GDBT_OCP_OFS)
            |=> (st_reg.overcurrent_blank_count == $past(REG_WDATA[GDBT_CNT_HI:GDBT_CNT_LO]));
    endproperty
    a_ocp_wr: assert property (p_ocp_wr) else $error("ocp count not stored");

    property p_rtoff_wr;
        @(posedge SYS_CLK) disable iff (RST)
            (REG_WR && !FRAME_BAD && REG_ADDR == GDBT_RTOFF_OFS)
            |=> (st_reg.regular_off_delay_count == $past(REG_WDATA[GDBT_CNT_HI:GDBT_CNT_LO]));
    endproperty
    a_rtoff_wr: assert property (p_rtoff_wr) else $error("delay count not stored");

    property p_ocp_off;
        @(posedge SYS_CLK) disable iff (RST)
            (st_reg.overcurrent_blank_count == GDBT_ZERO8 && SWITCH_EVT) |=> !ocp_blank;
    endproperty
    a_ocp_off: assert property (p_ocp_off) else $error("ocp blanking with zero field");

    property p_two_level_turn_off_off;
        @(posedge SYS_CLK) disable iff (RST)
            (st_reg.regular_off_delay_count == GDBT_ZERO8 && OFF_EVT) |=> ##1 !TWO_LEVEL_TURN_OFF_ACTIVE;
    endproperty
    a_two_level_turn_off_off: assert property (p_two_level_turn_off_off) else $error("two_level_turn_off with zero field");

    property p_blank;
        @(posedge SYS_CLK) disable iff (RST) desaturation_supervision_blank |=> !DESATURATION_SUPERVISION_FAULT;
    endproperty
    a_blank: assert property (p_blank) else $error("desaturation_supervision fault during blanking");

    c_desaturation_supervision_fault: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(DESATURATION_SUPERVISION_FAULT));
    c_two_level_turn_off: cover property (@(posedge SYS_CLK) disable iff (RST) $fell(TWO_LEVEL_TURN_OFF_ACTIVE));
    c_bad: cover property (@(posedge SYS_CLK) disable iff (RST) FRAME_DONE && FRAME_BAD);
endmodule : gdbt_bank

// ### verif/gdbt_host.sv
// Host model issuing register accesses, each framed by one frame verdict.
// Assumes the bench calls access() after reset; drives on falling edges.
`timescale 1ns/10ps
module gdbt_host
    import gdbt_pkg::*;
(
    // Clock
    input wire logic SYS_CLK,
    // Access request
    output logic REG_WR,
    output logic REG_RD,
    output logic [7:0] REG_ADDR,
    output logic [15:0] REG_WDATA,
    output logic FRAME_DONE,
    output logic FRAME_BAD,
    // Read return
    input wire logic [15:0] REG_RDATA,
    input wire logic REG_RVALID
);
    initial
    begin
        {REG_WR, REG_RD, FRAME_DONE, FRAME_BAD} = 4'h0;
        REG_ADDR = 8'h00;
        REG_WDATA = 16'h0000;
    end
    // ----------------------------------------
    // One access, field kept within host limits
    // ----------------------------------------
    task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
                          input logic bad, output logic [15:0] q, output logic v);
        logic [7:0] f;
        f = d[15:8];
        if (a == GDBT_DESATURATION_SUPERVISION_OFS && f < GDBT_DESATURATION_SUPERVISION_MIN)
            f = GDBT_DESATURATION_SUPERVISION_MIN;
        if (a == GDBT_OCP_OFS && f > GDBT_OCP_MAX)
            f = GDBT_OCP_MAX;
        if (a == GDBT_RTOFF_OFS && f == GDBT_ONE8)
            f = GDBT_RTOFF_MIN;
        @(negedge SYS_CLK);
        REG_WR = wr;
        REG_RD = !wr;
        REG_ADDR = a;
        REG_WDATA = {f, d[7:0]};
        FRAME_DONE = 1'b1;
        FRAME_BAD = bad;
        @(negedge SYS_CLK);
        q = REG_RDATA;
        v = REG_RVALID;
        {REG_WR, REG_RD, FRAME_DONE, FRAME_BAD} = 4'h0;
        REG_ADDR = ~a;
        REG_WDATA = ~REG_WDATA;
    endtask : access
endmodule : gdbt_host

// ### verif/tb_top.sv
// Self-checking bench for the blanking and turn-off delay register bank.
// Assumes the host model gdbt_host and both tick dividers set to 1.
`timescale 1ns/10ps
module tb_top
    import gdbt_pkg::*;
();
    logic sys_clk;
    logic rst;
    logic reg_wr, reg_rd, frame_done, frame_bad, reg_rvalid, v;
    logic switch_evt, off_evt, desaturation_supervision_cmp, ocp_cmp;
    logic desaturation_supervision_fault, ocp_fault, ocp_blank_on, two_level_turn_off_on, two_level_turn_off_active;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, q;
    int n_mismatch = 0;
    int check_count = 0;
    // ----------------------------------------
    // Clock, design and host
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    gdbt_bank #(.OSC_DIV(1), .SYNC_DIV(1)) i_dut (.SYS_CLK(sys_clk), .RST(rst),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .FRAME_DONE(frame_done), .FRAME_BAD(frame_bad), .REG_RDATA(reg_rdata),
        .REG_RVALID(reg_rvalid), .SWITCH_EVT(switch_evt), .OFF_EVT(off_evt),
        .DESATURATION_SUPERVISION_CMP(desaturation_supervision_cmp), .OCP_CMP(ocp_cmp), .DESATURATION_SUPERVISION_FAULT(desaturation_supervision_fault),
        .OCP_FAULT(ocp_fault), .OCP_BLANK_ON(ocp_blank_on), .TWO_LEVEL_TURN_OFF_ON(two_level_turn_off_on),
        .TWO_LEVEL_TURN_OFF_ACTIVE(two_level_turn_off_active));
    gdbt_host i_host (.SYS_CLK(sys_clk), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .FRAME_DONE(frame_done),
        .FRAME_BAD(frame_bad), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    function automatic logic [15:0] word(input logic [7:0] c, input logic f);
        return {c, 6'h00, f, ~^{c, f}};
    endfunction : word
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic bad);
        i_host.access(1'b1, a, d, bad, q, v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        i_host.access(1'b0, a, 16'h0000, 1'b0, q, v);
        check("rvalid", {15'h0000, v}, 16'h0001);
        check("rdata", q, e);
    endtask : rd
    function automatic logic pick(input int s);
        return (s == 0) ? desaturation_supervision_fault : (s == 1) ? ocp_fault : two_level_turn_off_active;
    endfunction : pick
    task automatic timer(input int s, input int n, input logic [2:0] e);
        logic [2:0] o;
        @(negedge sys_clk);
        switch_evt = (s != 2);
        off_evt = (s == 2);
        @(negedge sys_clk);
        switch_evt = 1'b0;
        off_evt = 1'b0;
        repeat (3) @(negedge sys_clk);
        o[2] = pick(s);
        repeat (n - 3) @(negedge sys_clk);
        o[1] = pick(s);
        repeat (3) @(negedge sys_clk);
        o[0] = pick(s);
        check("timer", {13'h0000, o}, {13'h0000, e});
    endtask : timer
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        #20000;
        n_mismatch++;
        print_verdict();
    end
    initial
    begin
        rst = 1'b1;
        {switch_evt, off_evt, desaturation_supervision_cmp, ocp_cmp} = 4'h0;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        desaturation_supervision_cmp = 1'b1;
        ocp_cmp = 1'b1;
        rd(GDBT_DESATURATION_SUPERVISION_OFS, GDBT_DESATURATION_SUPERVISION_RST);
        rd(GDBT_OCP_OFS, GDBT_OCP_RST);
        rd(GDBT_RTOFF_OFS, GDBT_RTOFF_RST);
        wr(GDBT_DESATURATION_SUPERVISION_OFS, 16'h0cff, 1'b0);
        rd(GDBT_DESATURATION_SUPERVISION_OFS, word(8'h0c, 1'b0));
        wr(GDBT_OCP_OFS, 16'h3000, 1'b0);
        rd(GDBT_OCP_OFS, word(8'h2f, 1'b0));
        wr(GDBT_OCP_OFS, 16'h08fc, 1'b0);
        rd(GDBT_OCP_OFS, word(8'h08, 1'b0));
        wr(GDBT_RTOFF_OFS, 16'h04fe, 1'b0);
        rd(GDBT_RTOFF_OFS, word(8'h04, 1'b0));
        rd(8'h1b, word(8'h00, 1'b0));
        timer(0, 12, 3'b001);
        timer(1, 8, 3'b001);
        timer(2, 4, 3'b110);
        check("enables", {14'h0000, ocp_blank_on, two_level_turn_off_on}, 16'h0003);
        wr(GDBT_OCP_OFS, 16'h2000, 1'b1);
        rd(GDBT_OCP_OFS, word(8'h08, 1'b1));
        rd(GDBT_OCP_OFS, word(8'h08, 1'b0));
        wr(GDBT_OCP_OFS, 16'h0000, 1'b0);
        wr(GDBT_RTOFF_OFS, 16'h0000, 1'b0);
        timer(1, 8, 3'b111);
        timer(2, 4, 3'b000);
        check("enables", {14'h0000, ocp_blank_on, two_level_turn_off_on}, 16'h0000);
        print_verdict();
    end
endmodule : tb_top
